// >>> logic/wtt_totalizer.sv
// weight totalizer: running total, weighment counter and auto total modes
//
// Overview of operation
// - each accepted weighment is added to the total and bumps the counter
// - the added value is the displayed weight, gross or net alike
// - manual mode: total key adds present settled weight if thresholds allow
// - manual total refused during motion unless motion check is off
// - only readings strictly above the high threshold are accumulated
// - after totaling, block further totals until weight drops below low threshold
// - mode 1: last settled reading held, added on return below threshold
// - mode 2: highest settled reading held, added on return below threshold
// - mode 3: add as soon as stable, then block until below threshold
// - mode 4: settled readings above high threshold averaged, totaled when load drops
// - modes 1, 2, 4 add only once weight falls below the threshold
// - mode 5: total settled readings inside the accept window
// - key press in auto modes toggles auto enable; adds need it set
// - clearing auto enable leaves total and counter unchanged
// - motion check setting ignored in auto modes; held and added readings need settling, the drop below low threshold does not
// - thresholds held as whole percent of capacity
// - high threshold at least one percent, low at least zero
// - high written below low forces low to high minus one percent
// - low written above high forces high to low plus one percent
// - clear last removes only the latest weighment and decrements counter
`timescale 1ns/1ps
`default_nettype none

module wtt_totalizer #(
	parameter int TW = 40,               // total accumulator width
	parameter int CW = 16                // weighment counter width
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [wtt_pkg::WTT_AW-1:0]    wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	input  wire wtt_pkg::wtt_reading_t         reading_i,
	input  wire logic [wtt_pkg::WTT_WW-1:0]    capacity_i,
	output logic      [TW-1:0]                 total_o,
	output logic      [CW-1:0]                 count_o,
	output logic                               auto_en_o,
	output logic                               armed_o
);
	import wtt_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		wtt_mode_t         mode;
		logic              mchk;
		logic [WTT_PW-1:0] hi_pct;
		logic [WTT_PW-1:0] lo_pct;
		logic [WTT_WW-1:0] hi_w;
		logic [WTT_WW-1:0] lo_w;
		logic [WTT_WW-1:0] acc_lo;
		logic [WTT_WW-1:0] acc_hi;
		logic [TW-1:0]     total;
		logic [CW-1:0]     count;
		logic [WTT_WW-1:0] last;
		logic              last_v;
		logic [WTT_WW-1:0] hold;
		logic              hold_v;
		logic [TW-1:0]     avg_sum;
		logic [CW-1:0]     avg_n;
		logic              armed;
		logic              auto_en;
		logic [WTT_WW-1:0] rd;
		logic              rd_motion;
		logic              rd_ok;
		logic              ack;
		logic [31:0]       dat;
	} wtt_state_t;

	wtt_state_t        st_reg;
	wtt_state_t        st_next;
	logic              add_fire;
	logic [WTT_WW-1:0] add_val;
	logic              key;
	logic              clr_last;
	logic              clr_all;
	logic              hi_wr;
	logic              lo_wr;

	// ==========================================================
	// helpers
	// threshold weight from percent and capacity
	function automatic logic [WTT_WW-1:0] thr_weight(input logic [WTT_PW-1:0] pct,
		input logic [WTT_WW-1:0] cap);
		logic [WTT_WW+WTT_PW-1:0] prod;
		prod = (WTT_WW+WTT_PW)'(pct) * (WTT_WW+WTT_PW)'(cap);
		return WTT_WW'(prod / (WTT_WW+WTT_PW)'(WTT_PCT_DIV));
	endfunction : thr_weight

	// byte-lane merge for partial wishbone writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	// ==========================================================
	// next state
	always_comb begin
		logic              req;
		logic [31:0]       wd;
		logic [WTT_PW-1:0] v;
		logic              stable;
		logic              above;
		logic              below;
		logic              auto_ok;
		req      = wb_cyc_i & wb_stb_i & ~st_reg.ack;
		wd       = 32'h0;
		v        = '0;
		stable   = 1'b0;
		above    = 1'b0;
		below    = 1'b0;
		auto_ok  = 1'b0;
		st_next  = st_reg;
		add_fire = 1'b0;
		add_val  = '0;
		key      = 1'b0;
		clr_last = 1'b0;
		clr_all  = 1'b0;
		hi_wr    = 1'b0;
		lo_wr    = 1'b0;
		st_next.ack = req;

		// read mux, data taken at the same edge as ack
		if (req) begin
			case (wb_adr_i)
				WTT_OFS_CTRL: begin
					st_next.dat = 32'h0;
					st_next.dat[WTT_CTRL_MODE_LSB +: 3] = st_reg.mode;
					st_next.dat[WTT_CTRL_MCHK_BIT]      = st_reg.mchk;
				end
				WTT_OFS_HI_PCT:   st_next.dat = 32'(st_reg.hi_pct);
				WTT_OFS_LO_PCT:   st_next.dat = 32'(st_reg.lo_pct);
				WTT_OFS_STATUS: begin
					st_next.dat = 32'h0;
					st_next.dat[WTT_ST_AUTO_BIT]  = st_reg.auto_en;
					st_next.dat[WTT_ST_ARMED_BIT] = st_reg.armed;
					st_next.dat[WTT_ST_HOLDV_BIT] = st_reg.hold_v;
					st_next.dat[WTT_ST_AVG_BIT]   = (st_reg.avg_n != '0);
					st_next.dat[WTT_ST_LASTV_BIT] = st_reg.last_v;
				end
				WTT_OFS_TOTAL_LO: st_next.dat = st_reg.total[31:0];
				WTT_OFS_TOTAL_HI: st_next.dat = 32'(st_reg.total[TW-1:32]);
				WTT_OFS_COUNT:    st_next.dat = 32'(st_reg.count);
				WTT_OFS_LAST:     st_next.dat = 32'(st_reg.last);
				WTT_OFS_HOLD:     st_next.dat = 32'(st_reg.hold);
				WTT_OFS_ACC_LO:   st_next.dat = 32'(st_reg.acc_lo);
				WTT_OFS_ACC_HI:   st_next.dat = 32'(st_reg.acc_hi);
				WTT_OFS_HI_W:     st_next.dat = 32'(st_reg.hi_w);
				WTT_OFS_LO_W:     st_next.dat = 32'(st_reg.lo_w);
				default:          st_next.dat = 32'h0;   // unmapped and command reads as zero
			endcase
		end

		// register writes; unmapped writes are acknowledged and dropped
		if (req && wb_we_i) begin
			case (wb_adr_i)
				WTT_OFS_CTRL: begin
					wd = lane_merge({27'h0, st_reg.mchk, 1'b0, st_reg.mode}, wb_dat_i, wb_sel_i);
					st_next.mode    = wtt_mode_t'(wd[WTT_CTRL_MODE_LSB +: 3]);
					st_next.mchk    = wd[WTT_CTRL_MCHK_BIT];
					// a mode change drops any half-built weighment
					st_next.hold_v  = 1'b0;
					st_next.avg_n   = '0;
					st_next.avg_sum = '0;
				end
				WTT_OFS_HI_PCT: begin
					if (wb_sel_i[0]) begin
						hi_wr = 1'b1;
						v = wb_dat_i[WTT_PW-1:0];
						if (v < WTT_PCT_HI_MIN) v = WTT_PCT_HI_MIN;
						if (v > WTT_PCT_MAX) v = WTT_PCT_MAX;
						st_next.hi_pct = v;
						if (v < st_reg.lo_pct) begin
							st_next.lo_pct = v - WTT_PCT_STEP;
						end
					end
				end
				WTT_OFS_LO_PCT: begin
					if (wb_sel_i[0]) begin
						lo_wr = 1'b1;
						v = wb_dat_i[WTT_PW-1:0];
						// low may not reach 100, high needs room above it
						if (v > WTT_PCT_MAX - WTT_PCT_STEP) v = WTT_PCT_MAX - WTT_PCT_STEP;
						st_next.lo_pct = v;
						if (v > st_reg.hi_pct) begin
							st_next.hi_pct = v + WTT_PCT_STEP;
						end
					end
				end
				WTT_OFS_CMD: begin
					if (wb_sel_i[0]) begin
						key      = wb_dat_i[WTT_CMD_KEY_BIT];
						clr_last = wb_dat_i[WTT_CMD_CLRL_BIT];
						clr_all  = wb_dat_i[WTT_CMD_CLRA_BIT];
					end
				end
				WTT_OFS_ACC_LO: st_next.acc_lo = WTT_WW'(lane_merge(32'(st_reg.acc_lo), wb_dat_i, wb_sel_i));
				WTT_OFS_ACC_HI: st_next.acc_hi = WTT_WW'(lane_merge(32'(st_reg.acc_hi), wb_dat_i, wb_sel_i));
				default: ;
			endcase
		end

		// threshold weights track percent and capacity every cycle
		st_next.hi_w = thr_weight(st_reg.hi_pct, capacity_i);
		st_next.lo_w = thr_weight(st_reg.lo_pct, capacity_i);

		// latest reading kept for the manual key
		stable = reading_i.valid & ~reading_i.motion;
		above  = reading_i.weight > st_reg.hi_w;
		below  = reading_i.valid & (reading_i.weight < st_reg.lo_w);
		if (reading_i.valid) begin
			st_next.rd        = reading_i.weight;
			st_next.rd_motion = reading_i.motion;
			st_next.rd_ok     = 1'b1;
		end
		// re-arm once the load is off
		if (below) begin
			st_next.armed = 1'b1;
		end

		// auto adds pause in the key cycle so a toggle-off never adds
		auto_ok = st_reg.auto_en & ~key;
		case (st_reg.mode)
			WTT_MANUAL: begin
				if (key && st_reg.rd_ok && st_reg.armed && st_reg.rd > st_reg.hi_w
					&& (!st_reg.rd_motion || !st_reg.mchk)) begin
					add_fire      = 1'b1;
					add_val       = st_reg.rd;
					st_next.armed = 1'b0;
				end
			end
			WTT_AUTONORM, WTT_AUTOPEAK: begin
				if (key) st_next.auto_en = ~st_reg.auto_en;
				if (auto_ok && st_reg.armed && stable && above) begin
					if (st_reg.mode == WTT_AUTONORM || !st_reg.hold_v
						|| reading_i.weight > st_reg.hold) begin
						st_next.hold = reading_i.weight;
					end
					st_next.hold_v = 1'b1;
				end
				// commit only on the way down
				if (auto_ok && below && st_reg.hold_v) begin
					add_fire       = 1'b1;
					add_val        = st_reg.hold;
					st_next.hold_v = 1'b0;
				end
			end
			WTT_AUTOLOAD: begin
				if (key) st_next.auto_en = ~st_reg.auto_en;
				if (auto_ok && st_reg.armed && stable && above) begin
					add_fire      = 1'b1;
					add_val       = reading_i.weight;
					st_next.armed = 1'b0;
				end
			end
			WTT_LOADDROP: begin
				if (key) st_next.auto_en = ~st_reg.auto_en;
				// counter saturation stops the average rather than wrapping
				if (auto_ok && st_reg.armed && stable && above && st_reg.avg_n != '1) begin
					st_next.avg_sum = st_reg.avg_sum + TW'(reading_i.weight);
					st_next.avg_n   = st_reg.avg_n + CW'(1);
				end
				if (auto_ok && below && st_reg.avg_n != '0) begin
					add_fire        = 1'b1;
					add_val         = WTT_WW'(st_reg.avg_sum / TW'(st_reg.avg_n));
					st_next.avg_sum = '0;
					st_next.avg_n   = '0;
				end
			end
			WTT_ONACCEPT: begin
				if (key) st_next.auto_en = ~st_reg.auto_en;
				if (auto_ok && st_reg.armed && stable && above
					&& reading_i.weight >= st_reg.acc_lo && reading_i.weight <= st_reg.acc_hi) begin
					add_fire      = 1'b1;
					add_val       = reading_i.weight;
					st_next.armed = 1'b0;
				end
			end
			default: ;
		endcase

		// clears first, then the new weighment on top
		if (clr_all) begin
			st_next.total  = '0;
			st_next.count  = '0;
			st_next.last_v = 1'b0;
		end else if (clr_last && st_reg.last_v) begin
			st_next.total  = st_reg.total - TW'(st_reg.last);
			st_next.count  = st_reg.count - CW'(1);
			st_next.last_v = 1'b0;
		end
		if (add_fire) begin
			st_next.total  = st_next.total + TW'(add_val);
			st_next.count  = st_next.count + CW'(1);
			st_next.last   = add_val;
			st_next.last_v = 1'b1;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg         <= '0;
			st_reg.mode    <= WTT_MANUAL;
			st_reg.mchk    <= 1'b1;
			st_reg.hi_pct  <= WTT_HI_RST;
			st_reg.lo_pct  <= WTT_LO_RST;
			st_reg.armed   <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign wb_ack_o  = st_reg.ack;
	assign wb_dat_o  = st_reg.dat;
	assign total_o   = st_reg.total;
	assign count_o   = st_reg.count;
	assign auto_en_o = st_reg.auto_en;
	assign armed_o   = st_reg.armed;

	// ==========================================================
	// assertions
	sequence s_add;
		add_fire && !clr_all && !clr_last;
	endsequence

	sequence s_hi_below_lo;
		hi_wr && wb_dat_i[WTT_PW-1:0] >= WTT_PCT_HI_MIN && wb_dat_i[WTT_PW-1:0] < st_reg.lo_pct;
	endsequence

	sequence s_lo_above_hi;
		lo_wr && wb_dat_i[WTT_PW-1:0] < WTT_PCT_MAX && wb_dat_i[WTT_PW-1:0] > st_reg.hi_pct;
	endsequence

	property p_add_count;
		@(posedge clk_i) disable iff (rst_i)
		s_add |=> (st_reg.count == $past(st_reg.count) + CW'(1))
			&& (st_reg.total == $past(st_reg.total) + TW'($past(add_val)));
	endproperty
	a_add_count: assert property (p_add_count) else $error("total or count not advanced");

	property p_motion_refuse;
		@(posedge clk_i) disable iff (rst_i)
		(st_reg.mode == WTT_MANUAL && key && st_reg.mchk && st_reg.rd_motion && !clr_all && !clr_last)
			|=> $stable(st_reg.total) && $stable(st_reg.count);
	endproperty
	a_motion_refuse: assert property (p_motion_refuse) else $error("manual total taken in motion");

	property p_above_high;
		@(posedge clk_i) disable iff (rst_i)
		add_fire && (st_reg.mode == WTT_MANUAL || st_reg.mode == WTT_AUTOLOAD
			|| st_reg.mode == WTT_ONACCEPT) |-> add_val > st_reg.hi_w;
	endproperty
	a_above_high: assert property (p_above_high) else $error("weight at or below high threshold added");

	property p_block_after;
		@(posedge clk_i) disable iff (rst_i)
		add_fire && (st_reg.mode == WTT_MANUAL || st_reg.mode == WTT_AUTOLOAD)
			|=> !st_reg.armed ##1 (!add_fire || st_reg.armed);
	endproperty
	a_block_after: assert property (p_block_after) else $error("re-arm missing after total");

	property p_add_on_drop;
		@(posedge clk_i) disable iff (rst_i)
		add_fire && (st_reg.mode == WTT_AUTONORM || st_reg.mode == WTT_AUTOPEAK
			|| st_reg.mode == WTT_LOADDROP) |-> reading_i.valid && reading_i.weight < st_reg.lo_w;
	endproperty
	a_add_on_drop: assert property (p_add_on_drop) else $error("auto total while load present");

	property p_toggle;
		@(posedge clk_i) disable iff (rst_i)
		key && st_reg.mode != WTT_MANUAL |=> st_reg.auto_en != $past(st_reg.auto_en);
	endproperty
	a_toggle: assert property (p_toggle) else $error("auto enable not toggled");

	property p_off_keeps;
		@(posedge clk_i) disable iff (rst_i)
		key && st_reg.auto_en && st_reg.mode != WTT_MANUAL && !clr_all && !clr_last
			|=> $stable(st_reg.total) && $stable(st_reg.count);
	endproperty
	a_off_keeps: assert property (p_off_keeps) else $error("total changed on auto off");

	property p_hi_forces_lo;
		@(posedge clk_i) disable iff (rst_i)
		s_hi_below_lo |=> st_reg.lo_pct == st_reg.hi_pct - WTT_PCT_STEP;
	endproperty
	a_hi_forces_lo: assert property (p_hi_forces_lo) else $error("low not forced below high");

	property p_lo_forces_hi;
		@(posedge clk_i) disable iff (rst_i)
		s_lo_above_hi |=> st_reg.hi_pct == st_reg.lo_pct + WTT_PCT_STEP;
	endproperty
	a_lo_forces_hi: assert property (p_lo_forces_hi) else $error("high not forced above low");

	property p_clear_last;
		@(posedge clk_i) disable iff (rst_i)
		clr_last && !clr_all && !add_fire && st_reg.last_v
			|=> st_reg.count == $past(st_reg.count) - CW'(1) && !st_reg.last_v;
	endproperty
	a_clear_last: assert property (p_clear_last) else $error("clear last did not decrement");

	property p_hi_min;
		@(posedge clk_i) disable iff (rst_i)
		hi_wr |=> st_reg.hi_pct >= WTT_PCT_HI_MIN && st_reg.hi_pct >= st_reg.lo_pct;
	endproperty
	a_hi_min: assert property (p_hi_min) else $error("high threshold under one percent");

endmodule : wtt_totalizer

`default_nettype wire

// >>> pkg/wtt_pkg.sv
// shared constants, register map and carrier types of the weight totalizer
package wtt_pkg;

	// ==========================================================
	// widths
	localparam int WTT_WW = 24;            // weight and capacity width
	localparam int WTT_PW = 7;             // percent field width
	localparam int WTT_AW = 8;             // wishbone byte address width

	// ==========================================================
	// register byte offsets
	localparam logic [WTT_AW-1:0] WTT_OFS_CTRL     = 8'h00;
	localparam logic [WTT_AW-1:0] WTT_OFS_HI_PCT   = 8'h04;
	localparam logic [WTT_AW-1:0] WTT_OFS_LO_PCT   = 8'h08;
	localparam logic [WTT_AW-1:0] WTT_OFS_CMD      = 8'h0c;
	localparam logic [WTT_AW-1:0] WTT_OFS_STATUS   = 8'h10;
	localparam logic [WTT_AW-1:0] WTT_OFS_TOTAL_LO = 8'h14;
	localparam logic [WTT_AW-1:0] WTT_OFS_TOTAL_HI = 8'h18;
	localparam logic [WTT_AW-1:0] WTT_OFS_COUNT    = 8'h1c;
	localparam logic [WTT_AW-1:0] WTT_OFS_LAST     = 8'h20;
	localparam logic [WTT_AW-1:0] WTT_OFS_HOLD     = 8'h24;
	localparam logic [WTT_AW-1:0] WTT_OFS_ACC_LO   = 8'h28;
	localparam logic [WTT_AW-1:0] WTT_OFS_ACC_HI   = 8'h2c;
	localparam logic [WTT_AW-1:0] WTT_OFS_HI_W     = 8'h30;
	localparam logic [WTT_AW-1:0] WTT_OFS_LO_W     = 8'h34;

	// ==========================================================
	// field positions
	localparam int WTT_CTRL_MODE_LSB = 0;  // mode in bits 2:0
	localparam int WTT_CTRL_MCHK_BIT = 4;  // manual motion check enable
	localparam int WTT_CMD_KEY_BIT   = 0;  // total key press
	localparam int WTT_CMD_CLRL_BIT  = 1;  // clear last weighment
	localparam int WTT_CMD_CLRA_BIT  = 2;  // clear total and counter
	localparam int WTT_ST_AUTO_BIT   = 0;
	localparam int WTT_ST_ARMED_BIT  = 1;
	localparam int WTT_ST_HOLDV_BIT  = 2;
	localparam int WTT_ST_AVG_BIT    = 3;
	localparam int WTT_ST_LASTV_BIT  = 4;

	// ==========================================================
	// percent limits and reset values
	localparam logic [WTT_PW-1:0] WTT_PCT_HI_MIN = 7'h01;
	localparam logic [WTT_PW-1:0] WTT_PCT_MAX    = 7'h64;  // 100 percent
	localparam logic [WTT_PW-1:0] WTT_PCT_STEP   = 7'h01;
	localparam logic [WTT_PW-1:0] WTT_HI_RST     = 7'h0a;
	localparam logic [WTT_PW-1:0] WTT_LO_RST     = 7'h05;
	localparam int                WTT_PCT_DIV    = 100;

	// ==========================================================
	// totalizing modes
	typedef enum logic [2:0] {
		WTT_MANUAL   = 3'h0,
		WTT_AUTONORM = 3'h1,
		WTT_AUTOPEAK = 3'h2,
		WTT_AUTOLOAD = 3'h3,
		WTT_LOADDROP = 3'h4,
		WTT_ONACCEPT = 3'h5
	} wtt_mode_t;

	// one reading from the weighing front end
	typedef struct packed {
		logic              valid;   // one-cycle strobe
		logic              motion;  // scale not settled
		logic [WTT_WW-1:0] weight;  // displayed weight, gross or net
	} wtt_reading_t;

endpackage : wtt_pkg

// >>> sim/testbench.sv
// self-checking testbench of the weight totalizer over wishbone and the reading link
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import wtt_pkg::*;

	// =====================================================
	// stimulus and observation signals
	logic                clk_i  = 1'b0;
	logic                rst_i  = 1'b1;
	logic                wb_cyc = 1'b0;
	logic                wb_stb = 1'b0;
	logic                wb_we  = 1'b0;
	logic [WTT_AW-1:0]   wb_adr = 8'h00;
	logic [31:0]         wb_dat = 32'h00000000;
	logic [31:0]         rd_dat;
	logic                wb_ack;
	logic                fe_go  = 1'b0;
	logic                fe_mot = 1'b0;
	logic [WTT_WW-1:0]   fe_w   = 24'h000000;
	wtt_reading_t        reading;
	logic [WTT_WW-1:0]   capacity;
	logic [39:0]         total;
	logic [15:0]         count;
	logic                auto_en;
	logic                armed;
	logic [31:0]         rv;
	int                  failures = 0;
	int                  checks   = 0;

	always #12.5 clk_i = ~clk_i;

	wtt_front_model #(.CAP(24'h0003e8)) front (.clk_i(clk_i), .rst_i(rst_i), .go_i(fe_go), .motion_i(fe_mot),
		.weight_i(fe_w), .reading_o(reading), .capacity_o(capacity));

	wtt_totalizer #(.TW(40), .CW(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(rd_dat),
		.wb_ack_o(wb_ack), .reading_i(reading), .capacity_i(capacity), .total_o(total), .count_o(count),
		.auto_en_o(auto_en), .armed_o(armed));

	// =====================================================
	// verdict and comparison
	task automatic finish_test;
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// classic single wishbone cycle; request held until ack is sampled, data taken at that edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_dat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			finish_test();
		end
		rv = rd_dat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h00000000);
		chk({32'h0, rv}, {32'h0, e});
	endtask : rdc

	// one reading from the front end, then time for the add to land
	task automatic rd_in(input logic [23:0] w, input logic m);
		@(posedge clk_i);
		fe_go  <= 1'b1;
		fe_w   <= w;
		fe_mot <= m;
		@(posedge clk_i);
		fe_go <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : rd_in

	task automatic tc(input logic [39:0] t, input logic [15:0] c);
		chk({8'h00, total, count}, {8'h00, t, c});
	endtask : tc

	// =====================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(WTT_OFS_HI_PCT, 32'h0000000a);
		rdc(WTT_OFS_LO_PCT, 32'h00000005);
		rdc(WTT_OFS_HI_W, 32'h00000064);
		rdc(WTT_OFS_LO_W, 32'h00000032);
		rdc(WTT_OFS_STATUS, 32'h00000002);
		rdc(8'h3c, 32'h00000000);
		// manual mode, motion check on
		rd_in(24'h0000c8, 1'b1);
		wr(WTT_OFS_CMD, 32'h1);
		tc(40'h0, 16'h0);
		rd_in(24'h0000c8, 1'b0);
		wr(WTT_OFS_CMD, 32'h1);
		tc(40'hc8, 16'h1);
		chk({63'h0, armed}, 64'h0);
		wr(WTT_OFS_CMD, 32'h1);
		tc(40'hc8, 16'h1);
		rd_in(24'h00001e, 1'b0);
		chk({63'h0, armed}, 64'h1);
		rd_in(24'h000064, 1'b0);
		wr(WTT_OFS_CMD, 32'h1);
		tc(40'hc8, 16'h1);
		rd_in(24'h000065, 1'b0);
		wr(WTT_OFS_CMD, 32'h1);
		tc(40'h12d, 16'h2);
		wr(WTT_OFS_CMD, 32'h2);
		tc(40'hc8, 16'h1);
		// manual with motion check off
		wr(WTT_OFS_CTRL, 32'h0);
		rd_in(24'h00001e, 1'b0);
		rd_in(24'h000096, 1'b1);
		wr(WTT_OFS_CMD, 32'h1);
		tc(40'h15e, 16'h2);
		// load mode
		wr(WTT_OFS_CTRL, 32'h3);
		wr(WTT_OFS_CMD, 32'h1);
		chk({63'h0, auto_en}, 64'h1);
		rd_in(24'h00001e, 1'b0);
		rd_in(24'h000078, 1'b1);
		tc(40'h15e, 16'h2);
		rd_in(24'h000078, 1'b0);
		tc(40'h1d6, 16'h3);
		rd_in(24'h000082, 1'b0);
		tc(40'h1d6, 16'h3);
		// last settled mode
		wr(WTT_OFS_CTRL, 32'h1);
		rd_in(24'h00001e, 1'b0);
		rd_in(24'h0000c8, 1'b0);
		rd_in(24'h0000b4, 1'b0);
		tc(40'h1d6, 16'h3);
		rd_in(24'h000028, 1'b0);
		tc(40'h28a, 16'h4);
		// peak mode
		wr(WTT_OFS_CTRL, 32'h2);
		rd_in(24'h0000c8, 1'b0);
		rd_in(24'h0000fa, 1'b0);
		rd_in(24'h0000dc, 1'b0);
		rd_in(24'h000028, 1'b0);
		tc(40'h384, 16'h5);
		// averaging mode
		wr(WTT_OFS_CTRL, 32'h4);
		wr(WTT_OFS_CMD, 32'h1);
		chk({63'h0, auto_en}, 64'h0);
		tc(40'h384, 16'h5);
		wr(WTT_OFS_CMD, 32'h1);
		rd_in(24'h0000c8, 1'b0);
		rd_in(24'h00012c, 1'b0);
		tc(40'h384, 16'h5);
		rd_in(24'h000028, 1'b0);
		tc(40'h47e, 16'h6);
		// accept window mode
		wr(WTT_OFS_CTRL, 32'h5);
		wr(WTT_OFS_ACC_LO, 32'h00000096);
		wr(WTT_OFS_ACC_HI, 32'h000000c8);
		rd_in(24'h0000fa, 1'b0);
		tc(40'h47e, 16'h6);
		rd_in(24'h0000af, 1'b0);
		tc(40'h52d, 16'h7);
		rdc(WTT_OFS_TOTAL_LO, 32'h0000052d);
		rdc(WTT_OFS_TOTAL_HI, 32'h00000000);
		rdc(WTT_OFS_COUNT, 32'h00000007);
		rdc(WTT_OFS_LAST, 32'h000000af);
		// threshold forcing and limits
		wr(WTT_OFS_HI_PCT, 32'h3);
		rdc(WTT_OFS_LO_PCT, 32'h00000002);
		wr(WTT_OFS_LO_PCT, 32'ha);
		rdc(WTT_OFS_HI_PCT, 32'h0000000b);
		wr(WTT_OFS_HI_PCT, 32'h0);
		rdc(WTT_OFS_HI_PCT, 32'h00000001);
		rdc(WTT_OFS_LO_PCT, 32'h00000000);
		rdc(WTT_OFS_HI_W, 32'h0000000a);
		wr(WTT_OFS_CMD, 32'h4);
		tc(40'h0, 16'h0);
		finish_test();
	end

endmodule : testbench

`default_nettype wire

// >>> sim/wtt_front_model.sv
// behavioural weighing front end feeding readings and capacity to the totalizer
`timescale 1ns/1ps
`default_nettype none

module wtt_front_model #(
	parameter logic [23:0] CAP = 24'h0003e8      // scale capacity handed out as a level
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       go_i,
	input  wire logic                       motion_i,
	input  wire logic [wtt_pkg::WTT_WW-1:0] weight_i,
	output var  wtt_pkg::wtt_reading_t      reading_o,
	output logic      [wtt_pkg::WTT_WW-1:0] capacity_o
);
	import wtt_pkg::*;

	// =====================================================
	// capacity
	assign capacity_o = CAP;

	// =====================================================
	// reading strobe: one cycle per request; between readings the data bits toggle,
	// so logic that wrongly uses an unstrobed value sees garbage, not the last weight
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reading_o <= '0;
		end else if (go_i) begin
			reading_o <= '{valid: 1'b1, motion: motion_i, weight: weight_i};
		end else begin
			reading_o.valid  <= 1'b0;
			reading_o.motion <= ~reading_o.motion;
			reading_o.weight <= ~reading_o.weight;
		end
	end

endmodule : wtt_front_model

`default_nettype wire
